// >>> verilog/lbc_pkg.sv
// constants shared by the led brightness current control block
package lbc_pkg;

   // register map (byte offsets on the host register port)
   localparam logic [7:0] CFG_ADDR        = 8'h10;
   localparam logic [7:0] BRT_ADDR        = 8'hA0;
   localparam logic [7:0] ZONE_BASE_ADDR  = 8'h70;
   localparam int         ZONE_COUNT      = 5;

   // values after reset
   localparam logic [7:0] CFG_RESET       = 8'h00;
   localparam logic [7:0] BRT_RESET       = 8'h00;
   localparam logic [7:0] ZONE_RESET      = 8'h00;

   // general configuration field positions
   localparam int         CFG_ENABLE_BIT  = 0;
   localparam int         CFG_LINEAR_BIT  = 1;
   localparam int         CFG_FS_LSB      = 2;
   localparam int         CFG_FS_MSB      = 4;
   localparam int         CFG_PWM_EN_BIT  = 5;
   localparam int         CFG_PWM_POL_BIT = 6;
   localparam int         CFG_SIMPLE_BIT  = 7;

   // full code used when the simple-enable bit overrides the host brightness register
   localparam logic [6:0] SIMPLE_CODE     = 7'h7F;

   // fraction of full scale in thousandths of a percent
   localparam logic [16:0] FULL_SCALE_MILLI = 17'h186A0;

   // full-scale current per field value, microamps; entries 4 and 5 fixed
   localparam logic [15:0] FS_UA [8] = '{16'h1388, 16'h2134, 16'h2EE0, 16'h36B0,
                                         16'h3C8C, 16'h57E4, 16'h6590, 16'h733C};

   // slowest legal pwm is 400 Hz; no edge for two such periods means a dc level
   localparam int unsigned CLK_PERIOD_NS       = 100;
   localparam int unsigned PWM_MIN_FREQ_HZ     = 400;
   localparam int unsigned PWM_MAX_PERIOD_NS   = 1000000000 / PWM_MIN_FREQ_HZ;
   localparam int unsigned PWM_TIMEOUT_DEFAULT = 2 * (PWM_MAX_PERIOD_NS / CLK_PERIOD_NS);

   // divider sequencing
   localparam logic [5:0] DIV_STEPS = 6'h21;

   typedef enum logic [1:0]
   {
      DIV_LOAD = 2'b01,
      DIV_RUN  = 2'b10
   } lbc_div_state_type;

endpackage

// >>> verilog/lbc_current_control.sv
// led current target: brightness source, mapping, pwm duty scaling, full scale
`timescale 1ns/1ps

module lbc_current_control
#(
   parameter int unsigned PWM_TIMEOUT_CYCLES = lbc_pkg::PWM_TIMEOUT_DEFAULT
)
(
   input  wire logic        MCLK,
   input  wire logic        RST_N,
   input  wire logic [7:0]  REG_ADDR,
   input  wire logic [7:0]  REG_WDATA,
   input  wire logic        REG_WR,
   output logic      [7:0]  REG_RDATA,
   input  wire logic        ALS_MODE,
   input  wire logic [2:0]  ALS_ZONE,
   input  wire logic        PWM,
   output logic             LED_ENABLE,
   output logic      [2:0]  FULL_SCALE_LED_CURRENT,
   output logic      [16:0] LED_FRACTION,
   output logic      [15:0] LED_CURRENT_UA
);
   import lbc_pkg::*;

   // exponential table, thousandths of a percent of full scale
   localparam int EXP_TABLE [128] = '{
      0, 80, 86, 94, 102, 109, 117, 125, 133, 141, 148, 156, 164, 172, 180, 188,
      203, 211, 227, 242, 250, 266, 281, 297, 320, 336, 352, 375, 398, 422, 445, 469,
      500, 523, 555, 586, 617, 656, 695, 734, 773, 820, 867, 914, 969, 1031, 1078, 1148,
      1219, 1281, 1359, 1430, 1523, 1594, 1688, 1781, 1898, 2016, 2109, 2250, 2367, 2508, 2648, 2789,
      2953, 3125, 3336, 3500, 3719, 3906, 4141, 4375, 4648, 4922, 5195, 5469, 5781, 6125, 6484, 6875,
      7266, 7656, 8047, 8594, 9063, 9609, 10078, 10781, 11250, 11953, 12656, 13359, 14219, 15000, 15859, 16875,
      17813, 18750, 19922, 20859, 22266, 23438, 24844, 26250, 27656, 29297, 31172, 32813, 34453, 35547, 38828,
      41016, 43203, 45938, 48438, 51406, 54141, 57031, 60703, 63984, 67813, 71875, 75781, 79688, 84375, 89844,
      94531, 100000};

   ////////////////////////////////////////////////////////////////////////////////
   // register file

   logic [7:0] cfg;
   logic [7:0] next_cfg;
   logic [7:0] brightness_code;
   logic [7:0] next_brt;
   logic [7:0] zone [ZONE_COUNT];
   logic [7:0] next_zone [ZONE_COUNT];
   logic [7:0] next_rdata;

   always_comb
   begin
      next_cfg   = cfg;
      next_brt   = brightness_code;
      next_rdata = 8'h00;
      for (int i = 0; i < ZONE_COUNT; i++)
      begin
         next_zone[i] = zone[i];
      end
      if (REG_WR)
      begin
         if (REG_ADDR == CFG_ADDR)
         begin
            next_cfg = REG_WDATA;
         end
         if (REG_ADDR == BRT_ADDR)
         begin
            next_brt = REG_WDATA;
         end
         for (int i = 0; i < ZONE_COUNT; i++)
         begin
            if (REG_ADDR == ZONE_BASE_ADDR + 8'(i))
            begin
               next_zone[i] = REG_WDATA;
            end
         end
      end
      // unmapped addresses read zero
      if (REG_ADDR == CFG_ADDR)
      begin
         next_rdata = cfg;
      end
      if (REG_ADDR == BRT_ADDR)
      begin
         next_rdata = brightness_code;
      end
      for (int i = 0; i < ZONE_COUNT; i++)
      begin
         if (REG_ADDR == ZONE_BASE_ADDR + 8'(i))
         begin
            next_rdata = zone[i];
         end
      end
   end

   always_ff @(posedge MCLK)
   begin
      if (!RST_N)
      begin
         cfg       <= CFG_RESET;
         brightness_code       <= BRT_RESET;
         REG_RDATA <= 8'h00;
         for (int i = 0; i < ZONE_COUNT; i++)
         begin
            zone[i] <= ZONE_RESET;
         end
      end
      else
      begin
         cfg       <= next_cfg;
         brightness_code       <= next_brt;
         REG_RDATA <= next_rdata;
         for (int i = 0; i < ZONE_COUNT; i++)
         begin
            zone[i] <= next_zone[i];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // brightness source and mapping

   logic [2:0]  zone_idx;
   logic [6:0]  code;
   logic [23:0] lin_full;
   logic [16:0] mapped;

   // out-of-range zone numbers fall back to the top zone
   assign zone_idx = (ALS_ZONE > 3'(ZONE_COUNT - 1)) ? 3'(ZONE_COUNT - 1) : ALS_ZONE;

   always_comb
   begin
      // simple enable hands brightness away from the host register
      if (cfg[CFG_SIMPLE_BIT])
      begin
         code = SIMPLE_CODE;
      end
      // ambient zone target or host brightness
      else if (ALS_MODE)
      begin
         code = zone[zone_idx][6:0];
      end
      else
      begin
         code = brightness_code[6:0];
      end
   end

   // linear step is 1/128 of full scale, offset by one above code zero
   assign lin_full = ((24'(code) + 24'h000001) * 24'(FULL_SCALE_MILLI)) >> 7;

   always_comb
   begin
      if (cfg[CFG_LINEAR_BIT])
      begin
         mapped = (code == 7'h00) ? 17'h00000 : lin_full[16:0];
      end
      else
      begin
         mapped = 17'(EXP_TABLE[code]);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // pwm input: three-stage sync, duty measured over each rising-edge period

   logic        pwm_s1;
   logic        pwm_s2;
   logic        pwm_s3;
   logic        pwm_level;
   logic        next_level;
   logic        pwm_active;
   logic [15:0] period_cnt;
   logic [15:0] next_period_cnt;
   logic [15:0] active_cnt;
   logic [15:0] next_active_cnt;
   logic [15:0] period_len;
   logic [15:0] next_period_len;
   logic [15:0] active_len;
   logic [15:0] next_active_len;

   // a level change counts only once stages two and three agree
   assign next_level = (pwm_s2 == pwm_s3) ? pwm_s3 : pwm_level;

   // polarity picks which half of the period is counted
   assign pwm_active = cfg[CFG_PWM_POL_BIT] ? ~next_level : next_level;

   always_comb
   begin
      next_period_cnt = period_cnt + 16'h0001;
      next_active_cnt = active_cnt + {15'h0000, pwm_active};
      next_period_len = period_len;
      next_active_len = active_len;
      if (next_level && !pwm_level)
      begin
         next_period_len = period_cnt;
         next_active_len = active_cnt;
         next_period_cnt = 16'h0001;
         next_active_cnt = {15'h0000, pwm_active};
      end
      // no edge within two slowest periods: pin is held, treat as dc
      else if (period_cnt >= 16'(PWM_TIMEOUT_CYCLES))
      begin
         next_period_len = 16'h0001;
         next_active_len = {15'h0000, pwm_active};
         next_period_cnt = 16'h0001;
         next_active_cnt = {15'h0000, pwm_active};
      end
   end

   always_ff @(posedge MCLK)
   begin
      if (!RST_N)
      begin
         pwm_s1     <= 1'b0;
         pwm_s2     <= 1'b0;
         pwm_s3     <= 1'b0;
         pwm_level  <= 1'b0;
         period_cnt <= 16'h0001;
         active_cnt <= 16'h0000;
         period_len <= 16'h0001;
         active_len <= 16'h0000;
      end
      else
      begin
         pwm_s1     <= PWM;
         pwm_s2     <= pwm_s1;
         pwm_s3     <= pwm_s2;
         pwm_level  <= next_level;
         period_cnt <= next_period_cnt;
         active_cnt <= next_active_cnt;
         period_len <= next_period_len;
         active_len <= next_active_len;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // serial divider: mapped * active / period, restarted after every result

   lbc_div_state_type div_state;
   lbc_div_state_type next_div_state;
   logic [32:0] div_num;
   logic [32:0] next_div_num;
   logic [16:0] div_rem;
   logic [16:0] next_div_rem;
   logic [15:0] div_den;
   logic [15:0] next_div_den;
   logic [5:0]  div_cnt;
   logic [5:0]  next_div_cnt;
   logic [16:0] pwm_frac;
   logic [16:0] next_pwm_frac;
   logic [16:0] rem_shift;

   assign rem_shift = {div_rem[15:0], div_num[32]};

   always_comb
   begin
      next_div_state = div_state;
      next_div_num   = div_num;
      next_div_rem   = div_rem;
      next_div_den   = div_den;
      next_div_cnt   = div_cnt;
      next_pwm_frac  = pwm_frac;
      unique case (div_state)
         DIV_LOAD:
         begin
            // duty scaling of the mapped fraction
            next_div_num   = 33'(mapped) * 33'(active_len);
            next_div_den   = period_len;
            next_div_rem   = 17'h00000;
            next_div_cnt   = 6'h00;
            next_div_state = DIV_RUN;
         end
         DIV_RUN:
         begin
            next_div_num = {div_num[31:0], 1'b0};
            next_div_rem = rem_shift;
            if (rem_shift >= {1'b0, div_den})
            begin
               next_div_rem    = rem_shift - {1'b0, div_den};
               next_div_num[0] = 1'b1;
            end
            next_div_cnt = div_cnt + 6'h01;
            if (div_cnt == DIV_STEPS - 6'h01)
            begin
               // quotient never exceeds mapped since active never exceeds period
               next_pwm_frac  = next_div_num[16:0];
               next_div_state = DIV_LOAD;
            end
         end
      endcase
   end

   always_ff @(posedge MCLK)
   begin
      if (!RST_N)
      begin
         div_state <= DIV_LOAD;
         div_num   <= 33'h000000000;
         div_rem   <= 17'h00000;
         div_den   <= 16'h0001;
         div_cnt   <= 6'h00;
         pwm_frac  <= 17'h00000;
      end
      else
      begin
         div_state <= next_div_state;
         div_num   <= next_div_num;
         div_rem   <= next_div_rem;
         div_den   <= next_div_den;
         div_cnt   <= next_div_cnt;
         pwm_frac  <= next_pwm_frac;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // output target

   logic        enabled;
   logic [16:0] next_fraction;
   logic [2:0]  next_fs;
   logic [15:0] next_current;
   logic [31:0] current_prod;

   assign enabled = cfg[CFG_ENABLE_BIT] | cfg[CFG_SIMPLE_BIT];

   always_comb
   begin
      // combine source, mapping and optional duty
      if (!enabled)
      begin
         next_fraction = 17'h00000;
      end
      else if (cfg[CFG_PWM_EN_BIT])
      begin
         next_fraction = pwm_frac;
      end
      else
      begin
         next_fraction = mapped;
      end
   end

   assign next_fs      = cfg[CFG_FS_MSB:CFG_FS_LSB];
   assign current_prod = 32'(FS_UA[FULL_SCALE_LED_CURRENT]) * 32'(LED_FRACTION);
   assign next_current = 16'(current_prod / 32'(FULL_SCALE_MILLI));

   always_ff @(posedge MCLK)
   begin
      if (!RST_N)
      begin
         LED_ENABLE             <= 1'b0;
         FULL_SCALE_LED_CURRENT <= CFG_RESET[CFG_FS_MSB:CFG_FS_LSB];
         LED_FRACTION           <= 17'h00000;
         LED_CURRENT_UA         <= 16'h0000;
      end
      else
      begin
         LED_ENABLE             <= enabled;
         FULL_SCALE_LED_CURRENT <= next_fs;
         LED_FRACTION           <= next_fraction;
         LED_CURRENT_UA         <= next_current;
      end
   end

endmodule

// >>> sim/lbc_current_control_asserts.sv
// port checker for the led current control block
`timescale 1ns/1ps
module lbc_current_control_asserts
   import lbc_pkg::*;
#(
   parameter int unsigned PWM_TIMEOUT_CYCLES = lbc_pkg::PWM_TIMEOUT_DEFAULT
)
(
   input wire logic        MCLK,
   input wire logic        RST_N,
   input wire logic [7:0]  REG_ADDR,
   input wire logic [7:0]  REG_WDATA,
   input wire logic        REG_WR,
   input wire logic [7:0]  REG_RDATA,
   input wire logic        ALS_MODE,
   input wire logic [2:0]  ALS_ZONE,
   input wire logic        PWM,
   input wire logic        LED_ENABLE,
   input wire logic [2:0]  FULL_SCALE_LED_CURRENT,
   input wire logic [16:0] LED_FRACTION,
   input wire logic [15:0] LED_CURRENT_UA
);
   logic [7:0]  cfg_shadow;
   logic [7:0]  next_cfg_shadow;
   logic [33:0] ua_product;
   logic        mapped;

   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RST_N);

   ////////////////////////////////////////////////////////////////////////////
   // shadow of the configuration, seen only through the write port
   always_comb
   begin
      next_cfg_shadow = cfg_shadow;
      if (!RST_N)
         next_cfg_shadow = CFG_RESET;
      else if (REG_WR && REG_ADDR == CFG_ADDR)
         next_cfg_shadow = REG_WDATA;
   end

   always_ff @(posedge MCLK)
   begin
      cfg_shadow <= next_cfg_shadow;
   end

   assign ua_product = 34'(FS_UA[FULL_SCALE_LED_CURRENT]) * 34'(LED_FRACTION);
   assign mapped     = REG_ADDR == CFG_ADDR || REG_ADDR == BRT_ADDR
                       || (REG_ADDR >= ZONE_BASE_ADDR && REG_ADDR < ZONE_BASE_ADDR + 8'(ZONE_COUNT));

   ////////////////////////////////////////////////////////////////////////////
   sequence cfg_write;
      REG_WR && REG_ADDR == CFG_ADDR;
   endsequence

   sequence quiet_two;
      !REG_WR [*2];
   endsequence

   sequence brt_write_then_read;
      (REG_WR && REG_ADDR == BRT_ADDR) ##1 (!REG_WR && REG_ADDR == BRT_ADDR);
   endsequence

   chk_reset_clear: assert property ($rose(RST_N) |-> LED_FRACTION == 17'h00000 && REG_RDATA == 8'h00 && !LED_ENABLE)
      else $error("outputs not clear after reset");
   chk_fs_copy: assert property (cfg_write ##1 quiet_two |-> FULL_SCALE_LED_CURRENT == cfg_shadow[4:2])
      else $error("full scale field not copied");
   chk_enable_copy: assert property (cfg_write ##1 quiet_two |-> LED_ENABLE == (cfg_shadow[0] | cfg_shadow[7]))
      else $error("enable output wrong");
   chk_current_scale: assert property ($stable(LED_FRACTION) && $stable(FULL_SCALE_LED_CURRENT)
      |-> LED_CURRENT_UA == 16'(ua_product / 34'h186A0)) else $error("current not full scale times fraction");
   chk_fraction_cap: assert property (LED_FRACTION <= FULL_SCALE_MILLI)
      else $error("fraction above full scale");
   chk_unmapped_zero: assert property (!$past(mapped) |-> REG_RDATA == 8'h00)
      else $error("unmapped address reads nonzero");
   chk_brt_readback: assert property (brt_write_then_read |=> REG_RDATA == $past(REG_WDATA, 2))
      else $error("brightness readback wrong");
   chk_pwm_ignored: assert property ((!cfg_shadow[5] && !REG_WR && $stable(ALS_MODE) && $stable(ALS_ZONE)) [*6]
      |-> $stable(LED_FRACTION)) else $error("fraction moved with pwm disabled");
   chk_simple_full: assert property ((cfg_shadow[7] && !cfg_shadow[5] && !REG_WR) [*4]
      |-> LED_FRACTION == FULL_SCALE_MILLI) else $error("simple enable not full code");
   chk_disabled_zero: assert property ((!cfg_shadow[0] && !cfg_shadow[7]) [*3] |-> LED_FRACTION == 17'h00000)
      else $error("fraction nonzero while disabled");
endmodule

bind lbc_current_control lbc_current_control_asserts #(.PWM_TIMEOUT_CYCLES(PWM_TIMEOUT_CYCLES)) u_chk
(
   .MCLK(MCLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
   .REG_RDATA(REG_RDATA), .ALS_MODE(ALS_MODE), .ALS_ZONE(ALS_ZONE), .PWM(PWM), .LED_ENABLE(LED_ENABLE),
   .FULL_SCALE_LED_CURRENT(FULL_SCALE_LED_CURRENT), .LED_FRACTION(LED_FRACTION), .LED_CURRENT_UA(LED_CURRENT_UA)
);

// >>> sim/lbc_pwm_source.sv
// behavioural pwm source standing in for the outside brightness controller
`timescale 1ns/1ps
module lbc_pwm_source
#(
   parameter int PERIOD_NS = 20000
)
(
   input  wire logic        run,
   input  wire logic        idle_level,
   input  wire logic [15:0] high_ns,
   output logic             pwm
);
   initial
   begin
      pwm = 1'b0;
      // let the bench set run and levels before they are first read
      #1;
      forever
      begin
         if (run)
         begin
            pwm = 1'b1;
            #(high_ns);
            pwm = 1'b0;
            #(PERIOD_NS - int'(high_ns));
         end
         else
         begin
            // pin rests at a level between bursts, no edges at all
            pwm = idle_level;
            #(PERIOD_NS);
         end
      end
   end
endmodule

// >>> sim/tb_top.sv
// self-checking bench for the led current control block
`timescale 1ns/1ps
module tb_top;
   import lbc_pkg::*;
   localparam int unsigned TIMEOUT_CYC = 2000;
   logic        mclk;
   logic        rst_n;
   logic [7:0]  reg_addr;
   logic [7:0]  reg_wdata;
   logic        reg_wr;
   logic [7:0]  reg_rdata;
   logic        als_mode;
   logic [2:0]  als_zone;
   logic        pwm;
   logic        led_enable;
   logic [2:0]  fs_code;
   logic [16:0] led_fraction;
   logic [15:0] led_current_ua;
   logic        pwm_run;
   logic        pwm_idle;
   logic [15:0] pwm_high_ns;
   int          errors;
   int          checks;
   logic [7:0]  t_cfg [7]  = '{8'h15, 8'h15, 8'h15, 8'h15, 8'h17, 8'h17, 8'h11};
   logic [7:0]  t_code [7] = '{8'h00, 8'h01, 8'h60, 8'h72, 8'h72, 8'h00, 8'h73};
   logic [16:0] t_frac [7] = '{17'h00000, 17'h00050, 17'h04595, 17'h0BD36, 17'h15EF3, 17'h00000, 17'h0C8CE};

   lbc_current_control #(.PWM_TIMEOUT_CYCLES(TIMEOUT_CYC)) dut
   (
      .MCLK(mclk), .RST_N(rst_n), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
      .REG_RDATA(reg_rdata), .ALS_MODE(als_mode), .ALS_ZONE(als_zone), .PWM(pwm), .LED_ENABLE(led_enable),
      .FULL_SCALE_LED_CURRENT(fs_code), .LED_FRACTION(led_fraction), .LED_CURRENT_UA(led_current_ua)
   );

   lbc_pwm_source u_pwm (.run(pwm_run), .idle_level(pwm_idle), .high_ns(pwm_high_ns), .pwm(pwm));

   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [16:0] expv, input logic [16:0] got, input int tol);
      checks++;
      if ($isunknown(got) || got > expv + 17'(tol) || got + 17'(tol) < expv)
      begin
         errors++;
         $display("MISMATCH %s expected %0d seen %0d", what, expv, got);
      end
   endtask

   task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk);
      reg_addr  = a;
      reg_wdata = d;
      reg_wr    = 1'b1;
      @(negedge mclk);
      reg_wr    = 1'b0;
   endtask

   task automatic reg_read(input logic [7:0] a, input logic [7:0] expv);
      @(negedge mclk);
      reg_addr = a;
      @(negedge mclk);
      check("register read", 17'(expv), 17'(reg_rdata), 0);
   endtask

   task automatic wait_cyc(input int n);
      repeat (n) @(negedge mclk);
   endtask

   // current is derived from the expected fraction, never from the outputs
   task automatic expect_out(input logic [7:0] cfg, input logic [16:0] frac, input int tol);
      logic [33:0] ua;
      ua = 34'(FS_UA[cfg[4:2]]) * 34'(frac) / 34'h186A0;
      check("led fraction", frac, led_fraction, tol);
      check("led current", 17'(ua), 17'(led_current_ua), tol + 1);
      check("full scale", 17'(cfg[4:2]), 17'(fs_code), 0);
      check("led enable", 17'(cfg[0] | cfg[7]), 17'(led_enable), 0);
   endtask

   task automatic conclude;
      $display("comparisons %0d mismatches %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   initial
   begin
      #2000000;
      errors++;
      conclude;
   end

   initial
   begin
      {rst_n, reg_wr, als_mode} = 3'b000;
      {reg_addr, reg_wdata, als_zone} = 19'h00000;
      {pwm_run, pwm_idle, pwm_high_ns} = {2'b10, 16'h36B0};
      {errors, checks} = 64'h0;
      wait_cyc(4);
      rst_n = 1'b1;
      reg_read(CFG_ADDR, CFG_RESET);
      reg_read(BRT_ADDR, BRT_RESET);
      reg_read(ZONE_BASE_ADDR, ZONE_RESET);
      expect_out(8'h00, 17'h00000, 0);
      // pwm runs at 70 percent throughout, so every row with a nonzero code also shows it is ignored
      for (int i = 0; i < 7; i++)
      begin
         reg_write(CFG_ADDR, t_cfg[i]);
         reg_write(BRT_ADDR, t_code[i]);
         wait_cyc(6);
         expect_out(t_cfg[i], t_frac[i], 0);
      end
      reg_read(BRT_ADDR, 8'h73);
      reg_write(8'h55, 8'hFF);
      reg_read(8'h55, 8'h00);
      reg_write(BRT_ADDR, 8'h01);
      reg_write(ZONE_BASE_ADDR + 8'h02, 8'h73);
      reg_write(ZONE_BASE_ADDR + 8'h04, 8'h60);
      als_mode = 1'b1;
      als_zone = 3'h2;
      wait_cyc(6);
      expect_out(8'h11, 17'h0C8CE, 0);
      als_zone = 3'h7;
      wait_cyc(6);
      expect_out(8'h11, 17'h04595, 0);
      reg_read(ZONE_BASE_ADDR + 8'h04, 8'h60);
      als_mode = 1'b0;
      wait_cyc(6);
      expect_out(8'h11, 17'h00050, 0);
      reg_write(CFG_ADDR, 8'h2D);
      reg_write(BRT_ADDR, 8'h73);
      wait_cyc(700);
      expect_out(8'h2D, 17'h08C90, 2);
      reg_write(CFG_ADDR, 8'h6D);
      wait_cyc(700);
      expect_out(8'h6D, 17'h03C3D, 2);
      // pin parked high: inactive for low polarity, fully active for high
      pwm_idle = 1'b1;
      pwm_run  = 1'b0;
      wait_cyc(TIMEOUT_CYC + 500);
      expect_out(8'h6D, 17'h00000, 0);
      reg_write(CFG_ADDR, 8'h2D);
      // a parked pin is only re-measured at the next idle timeout
      wait_cyc(TIMEOUT_CYC + 100);
      expect_out(8'h2D, 17'h0C8CE, 1);
      reg_write(CFG_ADDR, 8'h80);
      wait_cyc(6);
      expect_out(8'h80, FULL_SCALE_MILLI, 0);
      reg_write(CFG_ADDR, 8'h00);
      wait_cyc(6);
      expect_out(8'h00, 17'h00000, 0);
      conclude;
   end
endmodule
